// File: sam_mapper.sv
// Purpose: Channel select and row/column pin multiplexing
// Assumes: Config ports steady while a request is in flight
// Notes: Pins are driven on the memory clock
`timescale 1ns/1ps
`default_nettype none
module sam_mapper
	import sam_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic memory_clock_i,
	input wire logic [CHAN_COUNT-1:0][WIN_W-1:0] channel_base_i,
	input wire logic [CHAN_COUNT-1:0][WIN_W-1:0] channel_mask_field_i,
	input wire logic [CHAN_COUNT-1:0] bus_width_select_i,
	input wire logic [CHAN_COUNT-1:0][1:0] row_width_i,
	input wire logic [CHAN_COUNT-1:0][2:0] col_width_i,
	input wire logic [CHAN_COUNT-1:0] four_bank_i,
	input wire logic req_valid_i,
	input wire logic [PADDR_W-1:0] req_paddr_i,
	input wire logic req_precharge_i,
	output logic busy_o,
	output logic done_o,
	output logic miss_o,
	output logic multi_hit_o,
	output logic narrow_o,
	output logic [CHAN_COUNT-1:0] chan_select_o,
	output logic [PIN_W-1:0] mem_addr_o,
	output logic mem_phase_row_o,
	output logic mem_phase_col_o,
	output logic [CHAN_COUNT-1:0] mem_chan_o
);
	// ***************************************************************
	// Pin word builders
	// ***************************************************************
	function automatic logic [PIN_W-1:0] row_word(
		input logic [PADDR_W-1:0] a,
		input logic [1:0] rc,
		input logic [2:0] cc,
		input logic fb);
		logic [PIN_W-1:0] w;
		logic [5:0] b;
		w = PIN_RESET;
		b = BANK_BASE + {4'h0, rc} + {3'h0, cc};
		w[10:0] = a[21:11]; // R8
		w[11] = (rc >= 2'h1) ? a[22] : a[20]; // R8
		w[12] = (rc >= 2'h2) ? a[23] : a[21]; // R8
		w[BANK_LOW_BIT] = a[b]; // R4
		// Two-bank parts leave pin 18 as plain zero
		w[BANK_HIGH_BIT] = fb ? a[b + 6'h01] : 1'b0; // R5
		return w;
	endfunction

	function automatic logic [PIN_W-1:0] col_word(
		input logic [PADDR_W-1:0] a,
		input logic [1:0] rc,
		input logic [2:0] cc,
		input logic fb,
		input logic ap);
		logic [PIN_W-1:0] w;
		logic [PIN_W-1:0] r;
		logic [5:0] cb;
		r = row_word(a, rc, cc, fb);
		w = r;
		cb = COL_HIGH_BASE + {4'h0, rc};
		w[7:0] = a[COL_LOW_BASE +: 8]; // R7
		w[8] = (cc >= 3'h1) ? a[cb] : ap; // R6
		w[9] = (cc >= 3'h1) ? a[cb + 6'h01] : ap; // R6
		w[PRECHARGE_BIT] = ap; // R6
		w[11] = (cc >= 3'h3) ? a[cb + 6'h02] : r[11];
		w[12] = (cc >= 3'h4) ? a[cb + 6'h03] : r[12];
		return w;
	endfunction

	// ***************************************************************
	// Request side on clk_i
	// ***************************************************************
	logic [CHAN_COUNT-1:0] hit_vec;
	sam_cstate_t cstate, next_cstate;
	logic req_tog, next_req_tog;
	logic [PIN_W-1:0] lat_row, next_lat_row;
	logic [PIN_W-1:0] lat_col, next_lat_col;
	logic [PADDR_W-1:0] lat_paddr, next_lat_paddr;
	logic lat_ap, next_lat_ap;
	logic lat_fb, next_lat_fb;
	logic [5:0] lat_bank, next_lat_bank;
	logic [CHAN_COUNT-1:0] next_chan_select;
	logic next_busy, next_done, next_miss, next_multi, next_narrow;
	logic ack_sync, ack_seen, next_ack_seen;
	logic mem_ack_tog, next_mem_ack_tog;
	logic one_hit, sel_wide, accept;
	logic [1:0] sel_rc;
	logic [2:0] sel_cc;
	logic sel_fb;

	sam_decode u_decode (
		.paddr_i(req_paddr_i),
		.base_i(channel_base_i),
		.mask_i(channel_mask_field_i),
		.hit_o(hit_vec)
	);

	sam_sync u_ack_sync (
		.clk_i(clk_i),
		.d_i(mem_ack_tog),
		.q_o(ack_sync)
	);

	always_comb begin
		sel_wide = 1'b0;
		sel_rc = 2'h0;
		sel_cc = 3'h0;
		sel_fb = 1'b0;
		for (int i = 0; i < CHAN_COUNT; i++) begin
			if (hit_vec[i]) begin
				sel_wide = bus_width_select_i[i]; // R9
				sel_rc = row_width_i[i];
				sel_cc = col_width_i[i];
				sel_fb = four_bank_i[i];
			end
		end
		// Overlapping windows are refused, not resolved
		one_hit = $onehot(hit_vec); // R3
		accept = (cstate == SAM_C_IDLE) && req_valid_i && one_hit
			&& sel_wide; // R9
	end

	always_comb begin
		next_cstate = cstate;
		next_req_tog = req_tog;
		next_lat_row = lat_row;
		next_lat_col = lat_col;
		next_lat_paddr = lat_paddr;
		next_lat_ap = lat_ap;
		next_lat_fb = lat_fb;
		next_lat_bank = lat_bank;
		next_chan_select = chan_select_o;
		next_ack_seen = ack_seen;
		next_done = 1'b0;
		next_miss = 1'b0;
		next_multi = 1'b0;
		next_narrow = 1'b0;
		case (cstate)
			SAM_C_IDLE: begin
				if (accept) begin
					next_cstate = SAM_C_BUSY;
					next_req_tog = ~req_tog;
					next_lat_row = row_word(req_paddr_i, sel_rc, sel_cc,
						sel_fb); // R8
					next_lat_col = col_word(req_paddr_i, sel_rc, sel_cc,
						sel_fb, req_precharge_i); // R7
					next_lat_paddr = req_paddr_i;
					next_lat_ap = req_precharge_i;
					next_lat_fb = sel_fb;
					next_lat_bank = BANK_BASE + {4'h0, sel_rc}
						+ {3'h0, sel_cc};
					next_chan_select = hit_vec; // R2
				end else if (req_valid_i) begin
					next_miss = (hit_vec == CHAN_RESET); // R2
					next_multi = (hit_vec != CHAN_RESET) && !one_hit; // R3
					// 32-bit mapping lives elsewhere
					next_narrow = one_hit && !sel_wide; // R9
				end
			end
			SAM_C_BUSY: begin
				if (ack_sync != ack_seen) begin
					next_ack_seen = ack_sync;
					next_cstate = SAM_C_IDLE;
					next_done = 1'b1;
				end
			end
			default: next_cstate = SAM_C_IDLE;
		endcase
		next_busy = (next_cstate == SAM_C_BUSY);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cstate <= SAM_C_IDLE;
			req_tog <= 1'b0;
			lat_row <= PIN_RESET;
			lat_col <= PIN_RESET;
			lat_paddr <= '0;
			lat_ap <= 1'b0;
			lat_fb <= 1'b0;
			lat_bank <= 6'h00;
			chan_select_o <= CHAN_RESET;
			ack_seen <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			miss_o <= 1'b0;
			multi_hit_o <= 1'b0;
			narrow_o <= 1'b0;
		end else begin
			cstate <= next_cstate;
			req_tog <= next_req_tog;
			lat_row <= next_lat_row;
			lat_col <= next_lat_col;
			lat_paddr <= next_lat_paddr;
			lat_ap <= next_lat_ap;
			lat_fb <= next_lat_fb;
			lat_bank <= next_lat_bank;
			chan_select_o <= next_chan_select;
			ack_seen <= next_ack_seen;
			busy_o <= next_busy;
			done_o <= next_done;
			miss_o <= next_miss;
			multi_hit_o <= next_multi;
			narrow_o <= next_narrow;
		end
	end

	// ***************************************************************
	// Pin side on memory_clock_i
	// ***************************************************************
	// Latched words stay still until the ack returns, so no word sync
	logic mem_reset;
	logic req_sync, req_seen, next_req_seen;
	sam_mstate_t mstate, next_mstate;
	logic [PIN_W-1:0] next_mem_addr;
	logic next_phase_row, next_phase_col;
	logic [CHAN_COUNT-1:0] next_mem_chan;

	sam_sync u_rst_sync (
		.clk_i(memory_clock_i),
		.d_i(reset_i),
		.q_o(mem_reset)
	);

	sam_sync u_req_sync (
		.clk_i(memory_clock_i),
		.d_i(req_tog),
		.q_o(req_sync)
	);

	always_comb begin
		next_mstate = mstate;
		next_req_seen = req_seen;
		next_mem_ack_tog = mem_ack_tog;
		next_mem_addr = mem_addr_o;
		next_phase_row = 1'b0;
		next_phase_col = 1'b0;
		next_mem_chan = mem_chan_o;
		case (mstate)
			SAM_M_IDLE: begin
				if (req_sync != req_seen) begin
					next_req_seen = req_sync;
					next_mstate = SAM_M_ROW;
					next_mem_addr = lat_row; // R8
					next_mem_chan = chan_select_o;
					next_phase_row = 1'b1;
				end
			end
			SAM_M_ROW: begin
				next_mstate = SAM_M_COL;
				next_mem_addr = lat_col; // R7
				next_phase_col = 1'b1;
			end
			SAM_M_COL: begin
				next_mstate = SAM_M_IDLE;
				next_mem_ack_tog = ~mem_ack_tog;
			end
			default: next_mstate = SAM_M_IDLE;
		endcase
	end

	always_ff @(posedge memory_clock_i) begin
		if (mem_reset) begin
			mstate <= SAM_M_IDLE;
			req_seen <= 1'b0;
			mem_ack_tog <= 1'b0;
			mem_addr_o <= PIN_RESET;
			mem_phase_row_o <= 1'b0;
			mem_phase_col_o <= 1'b0;
			mem_chan_o <= CHAN_RESET;
		end else begin
			mstate <= next_mstate;
			req_seen <= next_req_seen;
			mem_ack_tog <= next_mem_ack_tog;
			mem_addr_o <= next_mem_addr;
			mem_phase_row_o <= next_phase_row;
			mem_phase_col_o <= next_phase_col;
			mem_chan_o <= next_mem_chan;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	sequence s_row_col;
		mem_phase_row_o ##1 mem_phase_col_o;
	endsequence

	a_accept_busy: assert property (@(posedge clk_i) // R9
		disable iff (reset_i)
		accept |=> busy_o && (req_tog != $past(req_tog)))
		else $error("Accepted request did not start");
	a_miss_flag: assert property (@(posedge clk_i) // R2
		disable iff (reset_i) (cstate == SAM_C_IDLE && req_valid_i
		&& hit_vec == 4'h0) |=> miss_o && !busy_o)
		else $error("Missed address not flagged");
	a_multi_flag: assert property (@(posedge clk_i) // R3
		disable iff (reset_i) (cstate == SAM_C_IDLE && req_valid_i
		&& $countones(hit_vec) > 1) |=> multi_hit_o && !busy_o)
		else $error("Overlap not refused");
	a_narrow_refused: assert property (@(posedge clk_i) // R9
		disable iff (reset_i) (cstate == SAM_C_IDLE && req_valid_i
		&& one_hit && !sel_wide) |=> narrow_o && !busy_o)
		else $error("32-bit channel not refused");
	a_select_onehot: assert property (@(posedge clk_i) // R1
		disable iff (reset_i) busy_o |-> $onehot(chan_select_o))
		else $error("Busy without single channel");
	a_done_bounded: assert property (@(posedge clk_i) // R9
		disable iff (reset_i) $rose(busy_o) |-> ##[1:100] done_o)
		else $error("Request never completed");
	a_row_then_col: assert property (@(posedge memory_clock_i) // R8
		disable iff (mem_reset)
		$rose(mem_phase_row_o) |-> s_row_col ##1 !mem_phase_col_o)
		else $error("Row not followed by column");
	a_row_low_bits: assert property (@(posedge memory_clock_i) // R8
		disable iff (mem_reset)
		mem_phase_row_o |-> mem_addr_o[10:0] == lat_paddr[21:11])
		else $error("Row pins wrong");
	a_col_low_bits: assert property (@(posedge memory_clock_i) // R7
		disable iff (mem_reset) mem_phase_row_o ##1 mem_phase_col_o
		|-> mem_addr_o[7:0] == lat_paddr[10:3])
		else $error("Column pins wrong");
	a_precharge_pin: assert property (@(posedge memory_clock_i) // R6
		disable iff (mem_reset)
		mem_phase_col_o |-> mem_addr_o[PRECHARGE_BIT] == lat_ap)
		else $error("Precharge pin wrong");
	a_bank_low: assert property (@(posedge memory_clock_i) // R4
		disable iff (mem_reset) mem_phase_row_o
		|-> mem_addr_o[BANK_LOW_BIT] == lat_paddr[lat_bank])
		else $error("Bank low pin wrong");
	a_bank_high: assert property (@(posedge memory_clock_i) // R5
		disable iff (mem_reset) (mem_phase_row_o && lat_fb)
		|-> mem_addr_o[BANK_HIGH_BIT] == lat_paddr[lat_bank + 6'h01])
		else $error("Bank high pin wrong");
	a_two_bank_pin: assert property (@(posedge memory_clock_i) // R5
		disable iff (mem_reset) (mem_phase_row_o && !lat_fb)
		|-> mem_addr_o[BANK_HIGH_BIT] == 1'b0)
		else $error("Pin 18 not low for two banks");
endmodule
`default_nettype wire

// File: sam_pkg.sv
// Purpose: Shared constants and types for the SDRAM channel address mapper
// Assumes: Four channels, 36-bit physical address, pins 19:5
// Notes: Overview of operation follows
//
// Overview of operation
// R1: Each channel has a base field and a mask field covering address 35:21.
// R2: A channel hits when all unmasked address bits 35:21 equal its base bits.
// R3: Software keeps channel windows apart; overlapping hits are undefined.
// R4: Two-bank memories take their bank select on address pin 19.
// R5: Four-bank memories take bank low on pin 19 and bank high on pin 18.
// R6: In the column phase pin 15 and other precharge pins show auto-precharge.
// R7: On a 64-bit channel column pins 12:5 carry address bits 10:3.
// R8: On a 64-bit channel row pins 15:5 carry address 21:11, upper bits by size.
// R9: Each channel has its own 64-bit or 32-bit bus width select. The mapper refuses requests to 32-bit channels with narrow_o.
package sam_pkg;
	// ***************************************************************
	// Sizes and field positions
	// ***************************************************************
	localparam int CHAN_COUNT = 4;
	localparam int PADDR_W = 36;
	localparam int WIN_HI = 35;
	localparam int WIN_LO = 21;
	localparam int WIN_W = WIN_HI - WIN_LO + 1;
	localparam int PIN_HI = 19;
	localparam int PIN_LO = 5;
	localparam int PIN_W = PIN_HI - PIN_LO + 1;
	localparam int BANK_LOW_BIT = 19 - PIN_LO;
	localparam int BANK_HIGH_BIT = 18 - PIN_LO;
	localparam int PRECHARGE_BIT = 15 - PIN_LO;
	// Physical address positions used by the 64-bit mapping
	localparam logic [5:0] COL_LOW_BASE = 6'h03;
	localparam logic [5:0] ROW_LOW_BASE = 6'h0B;
	localparam logic [5:0] COL_HIGH_BASE = 6'h16;
	localparam logic [5:0] BANK_BASE = 6'h16;
	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [PIN_W-1:0] PIN_RESET = 15'h0000;
	localparam logic [CHAN_COUNT-1:0] CHAN_RESET = 4'h0;
	typedef enum logic [0:0] {
		SAM_C_IDLE = 1'b0,
		SAM_C_BUSY = 1'b1
	} sam_cstate_t;
	typedef enum logic [1:0] {
		SAM_M_IDLE = 2'b00,
		SAM_M_ROW = 2'b01,
		SAM_M_COL = 2'b10
	} sam_mstate_t;
endpackage

// File: sam_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a slow level or toggle
// Notes: Only the second stage is visible
`timescale 1ns/1ps
`default_nettype none
module sam_sync
	import sam_pkg::*;
(
	input wire logic clk_i,
	input wire logic d_i,
	output logic q_o
);
	logic stage1;
	logic stage2;
	always_ff @(posedge clk_i) begin
		stage1 <= d_i;
		stage2 <= stage1;
	end
	assign q_o = stage2;
endmodule
`default_nettype wire

// File: sam_decode.sv
// Purpose: Channel window compare for all channels
// Assumes: Base and mask come from the same clock
// Notes: Purely combinational, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module sam_decode
	import sam_pkg::*;
(
	input wire logic [PADDR_W-1:0] paddr_i,
	input wire logic [CHAN_COUNT-1:0][WIN_W-1:0] base_i,
	input wire logic [CHAN_COUNT-1:0][WIN_W-1:0] mask_i,
	output logic [CHAN_COUNT-1:0] hit_o
);
	genvar g;
	generate
		for (g = 0; g < CHAN_COUNT; g++) begin : g_chan
			// Set mask bits widen the window
			assign hit_o[g] = ((paddr_i[WIN_HI:WIN_LO] ^ base_i[g])
				& ~mask_i[g]) == '0; // R1 R2
		end
	endgenerate
endmodule
`default_nettype wire

// File: sam_sdram_model.sv
// Purpose: Memory device stand-in that latches the row and column words
// Assumes: Words are taken on the rising memory clock edge
// Notes: Flags a column word that does not follow a row word directly
`timescale 1ns/1ps
`default_nettype none
module sam_sdram_model
	import sam_pkg::*;
(
	input wire logic memory_clock_i,
	input wire logic [PIN_W-1:0] mem_addr_i,
	input wire logic phase_row_i,
	input wire logic phase_col_i,
	input wire logic [CHAN_COUNT-1:0] mem_chan_i,
	output logic [PIN_W-1:0] row_word_o,
	output logic [PIN_W-1:0] col_word_o,
	output logic [CHAN_COUNT-1:0] chan_o,
	output logic [7:0] words_o,
	output logic order_err_o
);
	logic last_row;
	initial begin
		row_word_o = 15'h0000;
		col_word_o = 15'h0000;
		chan_o = 4'h0;
		words_o = 8'h00;
		order_err_o = 1'b0;
		last_row = 1'b0;
	end
	// Plain always: the latch has no reset of its own
	always @(posedge memory_clock_i) begin
		if (phase_row_i) begin
			row_word_o <= mem_addr_i;
			chan_o <= mem_chan_i;
		end
		if (phase_col_i) begin
			col_word_o <= mem_addr_i;
			order_err_o <= order_err_o | !last_row;
		end
		// Unknown phases before the link reset must not poison the count
		if (phase_row_i && phase_col_i)
			words_o <= words_o + 8'h02;
		else if (phase_row_i || phase_col_i)
			words_o <= words_o + 8'h01;
		last_row <= phase_row_i;
	end
endmodule
`default_nettype wire

// File: sam_mapper_tb_top.sv
// Purpose: Self-checking bench for the channel address mapper
// Assumes: Row and column codes 0 except in the wide row test
// Notes: Reset held long enough for the link domain to see it
`timescale 1ns/1ps
`default_nettype none
module sam_mapper_tb_top;
	import sam_pkg::*;
	logic clk_i, memory_clock_i, reset_i, req_valid_i, req_precharge_i;
	logic [CHAN_COUNT-1:0][WIN_W-1:0] base, mask;
	logic [CHAN_COUNT-1:0] width, fbank, chan_sel, mem_chan, m_chan;
	logic [PADDR_W-1:0] req_paddr_i;
	logic busy, done, miss, multi, narrow, ph_row, ph_col, m_err;
	logic [PIN_W-1:0] mem_addr, m_row, m_col;
	logic [7:0] m_words;
	logic [CHAN_COUNT-1:0][1:0] rwidth;
	logic [CHAN_COUNT-1:0][2:0] cwidth;
	int num_errors, comparisons, cycles;
	sam_mapper sam_mapper_i (.clk_i(clk_i), .reset_i(reset_i),
		.memory_clock_i(memory_clock_i), .channel_base_i(base),
		.channel_mask_field_i(mask), .bus_width_select_i(width),
		.row_width_i(rwidth), .col_width_i(cwidth), .four_bank_i(fbank),
		.req_valid_i(req_valid_i), .req_paddr_i(req_paddr_i),
		.req_precharge_i(req_precharge_i), .busy_o(busy), .done_o(done),
		.miss_o(miss), .multi_hit_o(multi), .narrow_o(narrow),
		.chan_select_o(chan_sel), .mem_addr_o(mem_addr),
		.mem_phase_row_o(ph_row), .mem_phase_col_o(ph_col),
		.mem_chan_o(mem_chan));
	sam_sdram_model sam_sdram_model_i (.memory_clock_i(memory_clock_i),
		.mem_addr_i(mem_addr), .phase_row_i(ph_row), .phase_col_i(ph_col),
		.mem_chan_i(mem_chan), .row_word_o(m_row), .col_word_o(m_col),
		.chan_o(m_chan), .words_o(m_words), .order_err_o(m_err));
	// ***************************************************************
	// Clocks and watchdog
	// ***************************************************************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		memory_clock_i = 1'b0;
		#37;
		forever #80 memory_clock_i = ~memory_clock_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end
	// ***************************************************************
	// Compare and drive tasks
	// ***************************************************************
	task automatic check_word(input string what, input logic [14:0] exp,
		input logic [14:0] got);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("Counts: %0d compared, %0d mismatched", comparisons,
			num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Expected pin word: codes 0, or row 13 and column 10 when big
	function automatic logic [14:0] exp_word(input logic [35:0] a,
		input logic fb, input logic ap, input logic col, input logic big);
		logic [14:0] r;
		r = {a[22], fb & a[23], a[21], a[20], a[21:11]};
		if (big)
			r[14:11] = {a[26], a[27], a[23], a[22]};
		if (col && big)
			r[10:0] = {ap, a[25], a[24], a[10:3]};
		else if (col)
			r[10:0] = {ap, ap, ap, a[10:3]};
		return r;
	endfunction
	task automatic access(input logic [35:0] a, input logic ap,
		input logic [3:0] ch, input logic fb, input logic big);
		int n;
		logic [7:0] w0;
		w0 = m_words;
		req_paddr_i = a;
		req_precharge_i = ap;
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		check_word("busy", 15'h0001, {14'h0, busy});
		check_word("chan_select", {11'h0, ch}, {11'h0, chan_sel});
		n = 0;
		while (done !== 1'b1 && n < 400) begin
			@(negedge clk_i);
			n++;
		end
		check_word("done", 15'h0001, {14'h0, done});
		check_word("words", 15'h0002, {7'h0, m_words - w0});
		check_word("order", 15'h0000, {14'h0, m_err});
		check_word("mem_chan", {11'h0, ch}, {11'h0, m_chan});
		check_word("row", exp_word(a, fb, ap, 1'b0, big), m_row);
		check_word("col", exp_word(a, fb, ap, 1'b1, big), m_col);
		@(negedge clk_i);
	endtask
	task automatic refuse(input logic [35:0] a, input logic [2:0] flags);
		req_paddr_i = a;
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		check_word("flags", {12'h0, flags}, {12'h0, miss, multi, narrow});
		check_word("busy", 15'h0000, {14'h0, busy});
		@(negedge clk_i);
	endtask
	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic test_four_bank();
		access({15'h01AB, 21'h15A5A8}, 1'b1, 4'h4, 1'b1, 1'b0);
		access({15'h01FF, 21'h1FFFF8}, 1'b0, 4'h4, 1'b1, 1'b0);
		$display("Test four_bank done");
	endtask
	task automatic test_two_bank();
		access({15'h0012, 21'h0F0F0F}, 1'b0, 4'h2, 1'b0, 1'b0);
		// Bit 23 set so a stray high bank bit on pin 18 shows
		access({15'h0007, 21'h1E5A37}, 1'b1, 4'h1, 1'b0, 1'b0);
		$display("Test two_bank done");
	endtask
	task automatic test_wide_row();
		rwidth[2] = 2'h2;
		cwidth[2] = 3'h2;
		@(negedge clk_i);
		access({15'h01D6, 21'h0A5C38}, 1'b1, 4'h4, 1'b1, 1'b1);
		rwidth[2] = 2'h0;
		cwidth[2] = 3'h0;
		@(negedge clk_i);
		$display("Test wide_row done");
	endtask
	task automatic test_refusals();
		refuse({15'h2000, 21'h000000}, 3'h4);
		refuse({15'h4000, 21'h000100}, 3'h1);
		base[3] = 15'h0010;
		mask[3] = 15'h0003;
		width[3] = 1'b1;
		@(negedge clk_i);
		// Overlap set on purpose, the software side breaks its duty here
		refuse({15'h0011, 21'h000000}, 3'h2);
		base[3] = 15'h4000;
		mask[3] = 15'h0000;
		width[3] = 1'b0;
		@(negedge clk_i);
		$display("Test refusals done");
	endtask
	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		reset_i = 1'b1;
		req_valid_i = 1'b0;
		req_precharge_i = 1'b0;
		req_paddr_i = 36'h000000000;
		base = {15'h4000, 15'h0100, 15'h0010, 15'h0000};
		mask = {15'h0000, 15'h00FF, 15'h0003, 15'h000F};
		width = 4'h7;
		fbank = 4'h4;
		rwidth = 8'h00;
		cwidth = 12'h000;
		// Longer than three memory clock cycles so the link domain sees reset
		repeat (24) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (40) @(negedge clk_i);
		test_four_bank();
		test_two_bank();
		test_wide_row();
		test_refusals();
		complete_run();
	end
endmodule
`default_nettype wire
